// >>> hw/reset_init_pkg.sv
// Constants and types for the reset state initialiser
package reset_init_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_STATUS  = 8'h00;
   localparam logic [7:0] OFS_PC_LO   = 8'h04;
   localparam logic [7:0] OFS_SP      = 8'h08;
   localparam logic [7:0] OFS_ACCU    = 8'h0C;
   localparam logic [7:0] OFS_TAB_LO  = 8'h10;
   localparam logic [7:0] OFS_TAB_HI  = 8'h14;
   localparam logic [7:0] OFS_IPTR0   = 8'h18;
   localparam logic [7:0] OFS_ICTL0   = 8'h1C;
   localparam logic [7:0] OFS_MODE    = 8'h20;
   localparam logic [7:0] OFS_PA      = 8'h24;
   localparam logic [7:0] OFS_PA_DIR  = 8'h28;
   localparam logic [7:0] OFS_PA_PU   = 8'h2C;
   localparam logic [7:0] OFS_PA_WU   = 8'h30;
   localparam logic [7:0] OFS_EVT_ST  = 8'h34;
   localparam logic [7:0] OFS_EVT_EN  = 8'h38;
   localparam logic [7:0] OFS_EVT_CLR = 8'h3C;
   localparam logic [7:0] OFS_CAUSE   = 8'h40;
   // Status flag positions
   localparam int TIMEOUT_BIT   = 5;
   localparam int POWERDOWN_BIT = 4;
   // Reset values
   localparam logic [7:0] STATUS_POR = 8'h00;
   localparam logic [7:0] BYTE_ZERO  = 8'h00;
   localparam logic [6:0] ICTL0_POR  = 7'h00;
   localparam logic [7:0] MODE_POR   = 8'h03;
   localparam logic [5:0] PORT_ONES  = 6'h3F;
   localparam logic [5:0] PORT_ZEROS = 6'h00;
   localparam logic [3:0] EVT_ZERO   = 4'h0;
   // Event bit positions
   localparam int EVT_POR  = 0;
   localparam int EVT_LOWV = 1;
   localparam int EVT_WRUN = 2;
   localparam int EVT_WSLP = 3;
   localparam int EVT_N    = 4;

   // Reset cause taken in a cycle, one-hot
   typedef enum logic [4:0] {
      CAUSE_NONE = 5'b0_0001,
      CAUSE_POR  = 5'b0_0010,
      CAUSE_LOWV = 5'b0_0100,
      CAUSE_WRUN = 5'b0_1000,
      CAUSE_WSLP = 5'b1_0000
   } cause_t;

   // Core state handed to the rest of the device
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] program_counter_low;
      logic [7:0] accumulator;
      logic [7:0] table_pointer_low;
      logic [7:0] table_pointer_high;
      logic [7:0] indirect_pointer_zero;
      logic [6:0] interrupt_control_zero;
      logic [7:0] system_mode_register;
      logic [5:0] port_a_data;
      logic [5:0] port_a_direction;
      logic [5:0] port_a_pullup;
      logic [5:0] port_a_wakeup;
   } core_state_t;
endpackage

// >>> hw/reset_state_initialiser.sv
// Reset cause decode and register initial conditions, APB slave
// Notes on behaviour
// - Sleep watchdog reset zeroes counter and stack pointer, sets timeout
// - Timeout and powerdown flags live in status; power-on clears both
// - Run-mode low-voltage reset keeps both flags
// - Run-mode watchdog reset sets timeout, keeps powerdown
// - Sleep or idle watchdog reset leaves both flags at one
// - Power-on disables every interrupt source in interrupt control; evt_enable, which gates irq, keeps its value
// - Power-on clears watchdog and time base; watchdog then counts
// - Power-on switches all timer modules off
// - Power-on makes every port pin an input
// - Power-on points the stack pointer at the stack top
// - Status: power-on xx00, low-voltage kept, watchdog xx1u / uu11
// - Counter low cleared always; pointers, interrupt control unless sleep
// - Port data, direction ones; pull-up, wake-up zeros unless sleep
// - Accumulator, table pointers kept unless power-on; mode reset unless sleep reset
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module reset_state_initialiser #(
   parameter int SP_W = 3
) (
   // APB slave
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   // Reset sources
   input  wire logic                      por_req,
   input  wire logic                      low_voltage_reset,
   input  wire logic                      watchdog_timeout,
   input  wire logic                      sleep_mode,
   // Core state and control
   output reset_init_pkg::core_state_t    core,
   output logic      [SP_W-1:0]           stack_ptr,
   output logic                           core_restart,
   output logic                           watchdog_clear,
   output logic                           tb_clear,
   output logic                           watchdog_enable,
   output logic                           timers_off,
   output logic                           irq
);
   reset_init_pkg::cause_t next_cause;
   reset_init_pkg::cause_t cause;
   logic                   wr;
   logic                   rd_setup;
   logic                   mapped;
   logic                   full;
   logic                   any_rst;
   logic [31:0]            next_rdata;
   logic [3:0]             evt_status;
   logic [3:0]             evt_enable;
   logic [3:0]             evt_hit;
   logic [3:0]             evt_clr;

   ////////////////////////////////////////////////////////////////////
   // Cause decode; low-voltage detection is off in sleep or idle
   always_comb begin
      if (por_req) begin
         next_cause = reset_init_pkg::CAUSE_POR;
      end else if (low_voltage_reset && !sleep_mode) begin
         next_cause = reset_init_pkg::CAUSE_LOWV;
      end else if (watchdog_timeout && !sleep_mode) begin
         next_cause = reset_init_pkg::CAUSE_WRUN;
      end else if (watchdog_timeout) begin
         next_cause = reset_init_pkg::CAUSE_WSLP;
      end else begin
         next_cause = reset_init_pkg::CAUSE_NONE;
      end
   end

   // Full resets rebuild pointers, ports and mode; sleep reset does not
   assign full = next_cause == reset_init_pkg::CAUSE_POR
      || next_cause == reset_init_pkg::CAUSE_LOWV
      || next_cause == reset_init_pkg::CAUSE_WRUN;
   assign any_rst = next_cause != reset_init_pkg::CAUSE_NONE;

   // Last cause taken, for software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause <= reset_init_pkg::CAUSE_POR;
      end else if (any_rst) begin
         cause <= next_cause;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // APB decode; every access completes without wait states
   assign wr       = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !mapped;

   // Status flags; a reset cause outranks a software write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core.status <= reset_init_pkg::STATUS_POR;
      end else begin
         case (next_cause)
            reset_init_pkg::CAUSE_POR: begin
               core.status <= reset_init_pkg::STATUS_POR;
            end
            reset_init_pkg::CAUSE_LOWV: core.status <= core.status;
            reset_init_pkg::CAUSE_WRUN: begin
               core.status[reset_init_pkg::TIMEOUT_BIT] <= 1'b1;
            end
            reset_init_pkg::CAUSE_WSLP: begin
               core.status[reset_init_pkg::TIMEOUT_BIT]   <= 1'b1;
               core.status[reset_init_pkg::POWERDOWN_BIT] <= 1'b1;
            end
            default: begin
               if (wr && paddr == reset_init_pkg::OFS_STATUS) begin
                  core.status <= pwdata[7:0];
               end
            end
         endcase
      end
   end

   // Counter low and stack pointer: zero on every cause
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core.program_counter_low  <= reset_init_pkg::BYTE_ZERO;
         stack_ptr <= '0;
      end else if (any_rst) begin
         core.program_counter_low  <= reset_init_pkg::BYTE_ZERO;
         stack_ptr <= '0;
      end else if (wr && paddr == reset_init_pkg::OFS_PC_LO) begin
         core.program_counter_low <= pwdata[7:0];
      end
   end

   // Working registers: only power-on defines them, others keep them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core.accumulator        <= reset_init_pkg::BYTE_ZERO;
         core.table_pointer_low  <= reset_init_pkg::BYTE_ZERO;
         core.table_pointer_high <= reset_init_pkg::BYTE_ZERO;
      end else if (next_cause == reset_init_pkg::CAUSE_POR) begin
         core.accumulator        <= reset_init_pkg::BYTE_ZERO;
         core.table_pointer_low  <= reset_init_pkg::BYTE_ZERO;
         core.table_pointer_high <= reset_init_pkg::BYTE_ZERO;
      end else if (wr && !any_rst) begin
         if (paddr == reset_init_pkg::OFS_ACCU) begin
            core.accumulator <= pwdata[7:0];
         end
         if (paddr == reset_init_pkg::OFS_TAB_LO) begin
            core.table_pointer_low <= pwdata[7:0];
         end
         if (paddr == reset_init_pkg::OFS_TAB_HI) begin
            core.table_pointer_high <= pwdata[7:0];
         end
      end
   end

   // Pointer, interrupt control, mode and port registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core.indirect_pointer_zero  <= reset_init_pkg::BYTE_ZERO;
         core.interrupt_control_zero <= reset_init_pkg::ICTL0_POR;
         core.system_mode_register   <= reset_init_pkg::MODE_POR;
         core.port_a_data            <= reset_init_pkg::PORT_ONES;
         core.port_a_direction       <= reset_init_pkg::PORT_ONES;
         core.port_a_pullup          <= reset_init_pkg::PORT_ZEROS;
         core.port_a_wakeup          <= reset_init_pkg::PORT_ZEROS;
      end else if (full) begin
         core.indirect_pointer_zero  <= reset_init_pkg::BYTE_ZERO;
         core.interrupt_control_zero <= reset_init_pkg::ICTL0_POR;
         core.system_mode_register   <= reset_init_pkg::MODE_POR;
         core.port_a_data            <= reset_init_pkg::PORT_ONES;
         core.port_a_direction       <= reset_init_pkg::PORT_ONES;
         core.port_a_pullup          <= reset_init_pkg::PORT_ZEROS;
         core.port_a_wakeup          <= reset_init_pkg::PORT_ZEROS;
      end else if (wr && !any_rst) begin
         case (paddr)
            reset_init_pkg::OFS_IPTR0: begin
               core.indirect_pointer_zero <= pwdata[7:0];
            end
            reset_init_pkg::OFS_ICTL0: begin
               core.interrupt_control_zero <= pwdata[6:0];
            end
            reset_init_pkg::OFS_MODE: begin
               core.system_mode_register <= pwdata[7:0];
            end
            reset_init_pkg::OFS_PA: begin
               core.port_a_data <= pwdata[5:0];
            end
            reset_init_pkg::OFS_PA_DIR: begin
               core.port_a_direction <= pwdata[5:0];
            end
            reset_init_pkg::OFS_PA_PU: begin
               core.port_a_pullup <= pwdata[5:0];
            end
            reset_init_pkg::OFS_PA_WU: begin
               core.port_a_wakeup <= pwdata[5:0];
            end
            default: begin
               core.indirect_pointer_zero <= core.indirect_pointer_zero;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Side effects of a reset: core_restart pulses on any cause, the clears and timers_off on a full reset; the watchdog never
   // stops, watchdog_enable stays high and it only restarts from a clear count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_restart    <= 1'b1;
         watchdog_clear  <= 1'b1;
         tb_clear        <= 1'b1;
         timers_off      <= 1'b1;
         watchdog_enable <= 1'b1;
      end else begin
         core_restart    <= any_rst;
         watchdog_clear  <= full;
         tb_clear        <= full;
         timers_off      <= full;
         watchdog_enable <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sticky event bits; a new event wins over a clear in the same cycle
   assign evt_hit = next_cause[4:1];
   assign evt_clr = (wr && paddr == reset_init_pkg::OFS_EVT_CLR)
      ? pwdata[3:0] : reset_init_pkg::EVT_ZERO;

   for (genvar i = 0; i < reset_init_pkg::EVT_N; i++) begin : g_evt
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            evt_status[i] <= 1'b0;
         end else if (evt_hit[i]) begin
            evt_status[i] <= 1'b1;
         end else if (evt_clr[i]) begin
            evt_status[i] <= 1'b0;
         end
      end
   end

   // Enable mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_enable <= reset_init_pkg::EVT_ZERO;
      end else if (wr && paddr == reset_init_pkg::OFS_EVT_EN) begin
         evt_enable <= pwdata[3:0];
      end
   end

   assign irq = |(evt_status & evt_enable);

   ////////////////////////////////////////////////////////////////////
   // Read mux; data is latched in the setup phase
   always_comb begin
      next_rdata = '0;
      mapped     = 1'b1;
      case (paddr)
         reset_init_pkg::OFS_STATUS:  next_rdata[7:0] = core.status;
         reset_init_pkg::OFS_PC_LO:   next_rdata[7:0] = core.program_counter_low;
         reset_init_pkg::OFS_SP:      next_rdata[SP_W-1:0] = stack_ptr;
         reset_init_pkg::OFS_ACCU:    next_rdata[7:0] = core.accumulator;
         reset_init_pkg::OFS_TAB_LO:  next_rdata[7:0] = core.table_pointer_low;
         reset_init_pkg::OFS_TAB_HI:  next_rdata[7:0] = core.table_pointer_high;
         reset_init_pkg::OFS_IPTR0:
            next_rdata[7:0] = core.indirect_pointer_zero;
         reset_init_pkg::OFS_ICTL0:
            next_rdata[6:0] = core.interrupt_control_zero;
         reset_init_pkg::OFS_MODE:
            next_rdata[7:0] = core.system_mode_register;
         reset_init_pkg::OFS_PA:      next_rdata[5:0] = core.port_a_data;
         reset_init_pkg::OFS_PA_DIR:  next_rdata[5:0] = core.port_a_direction;
         reset_init_pkg::OFS_PA_PU:   next_rdata[5:0] = core.port_a_pullup;
         reset_init_pkg::OFS_PA_WU:   next_rdata[5:0] = core.port_a_wakeup;
         reset_init_pkg::OFS_EVT_ST:  next_rdata[3:0] = evt_status;
         reset_init_pkg::OFS_EVT_EN:  next_rdata[3:0] = evt_enable;
         reset_init_pkg::OFS_EVT_CLR: next_rdata = '0;
         reset_init_pkg::OFS_CAUSE:   next_rdata[4:0] = cause;
         default:                     mapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (rd_setup) begin
         prdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_por_flags: assert property (
      por_req |=> !core.status[reset_init_pkg::TIMEOUT_BIT]
                  && !core.status[reset_init_pkg::POWERDOWN_BIT])
      else $error("power-on left a reset flag set");
   chk_lowv_keep: assert property (
      next_cause == reset_init_pkg::CAUSE_LOWV
      |=> core.status == $past(core.status))
      else $error("low-voltage reset changed status");
   chk_wrun_flags: assert property (
      next_cause == reset_init_pkg::CAUSE_WRUN
      |=> core.status[reset_init_pkg::TIMEOUT_BIT]
          && core.status[reset_init_pkg::POWERDOWN_BIT]
             == $past(core.status[reset_init_pkg::POWERDOWN_BIT]))
      else $error("run watchdog reset flags wrong");
   chk_wslp_state: assert property (
      next_cause == reset_init_pkg::CAUSE_WSLP
      |=> core.status[reset_init_pkg::TIMEOUT_BIT]
          && core.status[reset_init_pkg::POWERDOWN_BIT]
          && core.program_counter_low == 8'h00 && stack_ptr == '0
          && core.port_a_direction == $past(core.port_a_direction))
      else $error("sleep watchdog reset state wrong");
   chk_full_init: assert property (
      full |=> core.interrupt_control_zero == 7'h00
               && core.port_a_direction == 6'h3F
               && core.port_a_pullup == 6'h00
               && core.system_mode_register == 8'h03)
      else $error("full reset did not load defaults");
   // Pulse must follow the cause of the cycle before, not of this one
   chk_side_pulses: assert property (
      full |=> watchdog_clear && tb_clear && timers_off && watchdog_enable
               ##1 (watchdog_clear == $past(full)))
      else $error("full reset side effects wrong");
   chk_acc_keep: assert property (
      any_rst && !por_req
      |=> core.accumulator == $past(core.accumulator))
      else $error("accumulator changed on warm reset");
   chk_cause_order: assert property (
      por_req && watchdog_timeout
      |=> !core.status[reset_init_pkg::TIMEOUT_BIT]
          && cause == reset_init_pkg::CAUSE_POR)
      else $error("power-on did not outrank watchdog");

   cov_por: cover property (por_req ##1 core_restart);
   cov_wslp: cover property (
      next_cause == reset_init_pkg::CAUSE_WSLP ##1 core_restart);
   cov_lowv: cover property (next_cause == reset_init_pkg::CAUSE_LOWV);
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the reset state initialiser over APB
`timescale 1ns/100ps
module testbench;
   ////////////////////////////////////////////////////////////////////////
   // Stimulus and observed signals
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        por_req;
   logic        low_voltage_reset;
   logic        watchdog_timeout;
   logic        sleep_mode;
   logic        core_restart;
   logic        watchdog_clear;
   logic        tb_clear;
   logic        watchdog_enable;
   logic        timers_off;
   logic        irq;
   logic [2:0]  stack_ptr;
   logic        last_err;
   logic [31:0] rdat;
   int          mismatches;
   int          compares;
   reset_init_pkg::core_state_t core;

   // Register table: offset, fill value, default, kept by full resets other than power-on
   localparam logic [7:0] OFFS [10] = '{reset_init_pkg::OFS_ACCU,
      reset_init_pkg::OFS_TAB_LO, reset_init_pkg::OFS_TAB_HI,
      reset_init_pkg::OFS_IPTR0, reset_init_pkg::OFS_ICTL0,
      reset_init_pkg::OFS_MODE, reset_init_pkg::OFS_PA,
      reset_init_pkg::OFS_PA_DIR, reset_init_pkg::OFS_PA_PU,
      reset_init_pkg::OFS_PA_WU};
   localparam logic [7:0] FILL [10] = '{8'hA5, 8'h5A, 8'h3C, 8'h77,
      8'h55, 8'hE4, 8'h15, 8'h2A, 8'h3F, 8'h21};
   localparam logic [7:0] DFLT [10] = '{8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h03, 8'h3F, 8'h3F, 8'h00, 8'h00};
   localparam logic KEEP [10] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0,
      1'b0, 1'b0, 1'b0, 1'b0};

   ////////////////////////////////////////////////////////////////////////
   // Clock and device under test
   always #25 pclk = ~pclk;

   reset_state_initialiser #(.SP_W(3)) i_dut (
      .pclk              (pclk),
      .presetn           (presetn),
      .psel              (psel),
      .penable           (penable),
      .pwrite            (pwrite),
      .paddr             (paddr),
      .pwdata            (pwdata),
      .prdata            (prdata),
      .pready            (pready),
      .pslverr           (pslverr),
      .por_req           (por_req),
      .low_voltage_reset (low_voltage_reset),
      .watchdog_timeout  (watchdog_timeout),
      .sleep_mode        (sleep_mode),
      .core              (core),
      .stack_ptr         (stack_ptr),
      .core_restart      (core_restart),
      .watchdog_clear    (watchdog_clear),
      .tb_clear          (tb_clear),
      .watchdog_enable   (watchdog_enable),
      .timers_off        (timers_off),
      .irq               (irq)
   );

   ////////////////////////////////////////////////////////////////////////
   // Comparison, bus and reset-cause tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Hold the request until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      // A transfer that never completes counts against the run
      chk({31'h0, pready}, 32'h0000_0001);
      rdat     = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdat, exp);
   endtask

   // Request bits are {power-on, low voltage, watchdog, sleep}
   task automatic cause(input logic [3:0] req, input logic exp_rst,
                        input logic exp_full);
      @(posedge pclk);
      por_req           <= req[3];
      low_voltage_reset <= req[2];
      watchdog_timeout  <= req[1];
      sleep_mode        <= req[0];
      @(posedge pclk);
      por_req           <= 1'b0;
      low_voltage_reset <= 1'b0;
      watchdog_timeout  <= 1'b0;
      #1;
      chk({31'h0, core_restart}, {31'h0, exp_rst});
      chk({29'h0, watchdog_clear, tb_clear, timers_off},
          {29'h0, {3{exp_full}}});
      chk({29'h0, stack_ptr}, 32'h0000_0000);
      @(posedge pclk);
      sleep_mode <= 1'b0;
   endtask

   task automatic fill_regs(input logic [7:0] st);
      for (int i = 0; i < 10; i++) apb(1'b1, OFFS[i], {24'h0, FILL[i]});
      apb(1'b1, reset_init_pkg::OFS_PC_LO, 32'h0000_009C);
      apb(1'b1, reset_init_pkg::OFS_STATUS, {24'h0, st});
   endtask

   // Mode 0 power-on, 1 full reset, 2 sleep watchdog, 3 nothing taken
   task automatic check_regs(input int mode);
      logic [7:0] e;
      for (int i = 0; i < 10; i++) begin
         e = (mode >= 2 || (mode == 1 && KEEP[i])) ? FILL[i] : DFLT[i];
         rd(OFFS[i], {24'h0, e});
      end
      e = (mode == 3) ? 8'h9C : 8'h00;
      rd(reset_init_pkg::OFS_PC_LO, {24'h0, e});
   endtask

   task automatic chk_irq(input logic exp);
      #1;
      chk({31'h0, irq}, {31'h0, exp});
   endtask

   task automatic tally_and_finish;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watchdog against a hung bench
   initial begin
      repeat (5000) @(posedge pclk);
      mismatches++;
      tally_and_finish;
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
      pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
      por_req = 1'b0; low_voltage_reset = 1'b0;
      watchdog_timeout = 1'b0; sleep_mode = 1'b0;
      mismatches = 0; compares = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      #1;
      chk({30'h0, watchdog_clear, watchdog_enable}, 32'h0000_0001);
      chk({29'h0, stack_ptr}, 32'h0000_0000);
      check_regs(0);
      rd(reset_init_pkg::OFS_STATUS, 32'h0000_0000);
      apb(1'b1, reset_init_pkg::OFS_EVT_CLR, 32'h0000_000F);
      rd(reset_init_pkg::OFS_EVT_ST, 32'h0000_0000);
      // Run-mode low voltage: flags kept, most registers to defaults
      fill_regs(8'h30);
      cause(4'b0100, 1'b1, 1'b1);
      rd(reset_init_pkg::OFS_STATUS, 32'h0000_0030);
      check_regs(1);
      // Run-mode watchdog: timeout set, powerdown kept
      fill_regs(8'h50);
      cause(4'b0010, 1'b1, 1'b1);
      rd(reset_init_pkg::OFS_STATUS, 32'h0000_0070);
      check_regs(1);
      // Sleep watchdog: both flags one, only counter and stack cleared
      fill_regs(8'h00);
      cause(4'b0011, 1'b1, 1'b0);
      rd(reset_init_pkg::OFS_STATUS, 32'h0000_0030);
      check_regs(2);
      // Low voltage while asleep is not taken, nothing changes
      fill_regs(8'h00);
      cause(4'b0101, 1'b0, 1'b0);
      rd(reset_init_pkg::OFS_STATUS, 32'h0000_0000);
      check_regs(3);
      // Interrupt: sticky status, mask, write-one clear
      rd(reset_init_pkg::OFS_EVT_ST, 32'h0000_000E);
      apb(1'b1, reset_init_pkg::OFS_EVT_EN, 32'h0000_0001);
      chk_irq(1'b0);
      apb(1'b1, reset_init_pkg::OFS_EVT_EN, 32'h0000_0004);
      chk_irq(1'b1);
      apb(1'b1, reset_init_pkg::OFS_EVT_CLR, 32'h0000_0004);
      chk_irq(1'b0);
      rd(reset_init_pkg::OFS_EVT_ST, 32'h0000_000A);
      rd(reset_init_pkg::OFS_EVT_CLR, 32'h0000_0000);
      // Read-only stack pointer and an unmapped place
      apb(1'b1, reset_init_pkg::OFS_SP, 32'h0000_0007);
      rd(reset_init_pkg::OFS_SP, 32'h0000_0000);
      rd(8'h44, 32'h0000_0000);
      chk({31'h0, last_err}, 32'h0000_0001);
      // All causes at once: power-on wins alone
      apb(1'b1, reset_init_pkg::OFS_EVT_CLR, 32'h0000_000F);
      fill_regs(8'hFF);
      cause(4'b1110, 1'b1, 1'b1);
      rd(reset_init_pkg::OFS_STATUS, 32'h0000_0000);
      check_regs(0);
      rd(reset_init_pkg::OFS_EVT_ST, 32'h0000_0001);
      // Low voltage with watchdog in run mode: low voltage wins
      apb(1'b1, reset_init_pkg::OFS_EVT_CLR, 32'h0000_000F);
      apb(1'b1, reset_init_pkg::OFS_STATUS, 32'h0000_0000);
      cause(4'b0110, 1'b1, 1'b1);
      rd(reset_init_pkg::OFS_STATUS, 32'h0000_0000);
      rd(reset_init_pkg::OFS_EVT_ST, 32'h0000_0002);
      tally_and_finish;
   end
endmodule
